/* esh_defs.svh */
// Constants for the external start and halt input logic.
`ifndef ESH_DEFS_SVH
`define ESH_DEFS_SVH
`define ESH_CLK_PERIOD_NS 5
`define ESH_FLT_TIME_NS 40
`define ESH_FLT_CYCLES ((`ESH_FLT_TIME_NS + `ESH_CLK_PERIOD_NS - 1) / `ESH_CLK_PERIOD_NS)
`define ESH_FLT_CNT_W 4
`define ESH_CFG_EXT_MODE_LSB 0
`define ESH_CFG_FLT_EN_BIT 2
`define ESH_NUM_AXES 2
`endif

/* esh_pkg.sv */
// Types shared by the external start and halt input logic.
package esh_pkg;
	typedef enum logic [1:0] {
		ESH_EXT_OFF = 2'b00,
		ESH_EXT_FIXED = 2'b01,
		ESH_EXT_CONT = 2'b10
	} esh_ext_mode_t;
	typedef struct packed {
		logic flt_en;
		esh_ext_mode_t ext_mode;
	} esh_axis_cfg_t;
	typedef struct packed {
		logic start_plus;
		logic start_minus;
		logic run_plus;
		logic run_minus;
		logic halt;
	} esh_axis_req_t;
	typedef enum logic [1:0] {
		ESH_ST_IDLE = 2'b00,
		ESH_ST_FIXED = 2'b01,
		ESH_ST_CONT = 2'b11,
		ESH_ST_HALT = 2'b10
	} esh_axis_state_t;
endpackage

/* esh_in_filter.sv */
// Synchroniser and noise filter for one active-low input.
`timescale 1ns/10ps
`include "esh_defs.svh"
module esh_in_filter
	import esh_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic pin_n,
	input wire logic flt_en,
	output logic level_n
);
	logic sync_a;
	logic sync_b;
	logic [`ESH_FLT_CNT_W-1:0] cnt;
	logic [`ESH_FLT_CNT_W-1:0] next_cnt;
	logic next_level_n;
	localparam logic [`ESH_FLT_CNT_W-1:0] FLT_LAST = `ESH_FLT_CNT_W'(`ESH_FLT_CYCLES - 1);

	// Two-stage synchroniser; the first stage feeds only the second.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end else begin
			sync_a <= pin_n;
			sync_b <= sync_a;
		end
	end

	// With the filter on, the level changes only after it has differed for the full filter time.
	always_comb begin
		next_cnt = '0;
		next_level_n = level_n;
		if (!flt_en) begin
			next_level_n = sync_b;
		end else if (sync_b != level_n) begin
			if (cnt == FLT_LAST) begin
				next_level_n = sync_b;
			end else begin
				next_cnt = cnt + 1'b1;
			end
		end
	end

	// Filter state registers.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			level_n <= 1'b1;
		end else begin
			cnt <= next_cnt;
			level_n <= next_level_n;
		end
	end
endmodule // esh_in_filter

/* esh_ext_start_halt.sv */
// External start and global halt logic for a two-axis motion controller.
`timescale 1ns/10ps
`include "esh_defs.svh"
module esh_ext_start_halt
	import esh_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic x_ext_plus_start,
	input wire logic x_ext_minus_start,
	input wire logic y_ext_plus_start,
	input wire logic y_ext_minus_start,
	input wire logic global_halt_n,
	input wire esh_axis_cfg_t x_axis_mode_cfg_three,
	input wire esh_axis_cfg_t y_axis_mode_cfg_three,
	input wire logic [`ESH_NUM_AXES-1:0] drive_done,
	input wire logic [`ESH_NUM_AXES-1:0] halt_error_clear,
	output esh_axis_req_t x_req,
	output esh_axis_req_t y_req,
	output logic [`ESH_NUM_AXES-1:0] halt_error_flag,
	output esh_axis_state_t [`ESH_NUM_AXES-1:0] axis_state
);
	////////////////////////////////////////////////////////////////////////////////
	// Input conditioning.
	// Every pin passes a two-flop synchroniser and then the noise filter.
	// With the filter off a pin change reaches the request outputs three edges
	// after the first edge that samples it: two synchroniser stages, the filter
	// register and the request register; a continuous run takes one edge more
	// for the step from IDLE to CONT.
	// With the filter on the new level must stand for eight cycles, seven edges more than with the filter off.
	// With the filter on, pulses shorter than the filter time never reach the axis logic, so the
	// outside source must hold a start or halt level at least that long.
	// Inputs are taken as synchronous to ref_clk; the synchroniser still
	// guards against metastability when a switch is wired straight to a pin.
	esh_axis_cfg_t cfg [`ESH_NUM_AXES];
	logic [`ESH_NUM_AXES-1:0] plus_pin_n;
	logic [`ESH_NUM_AXES-1:0] minus_pin_n;
	logic [`ESH_NUM_AXES-1:0] plus_n;
	logic [`ESH_NUM_AXES-1:0] minus_n;
	logic [`ESH_NUM_AXES-1:0] plus_prev_n;
	logic [`ESH_NUM_AXES-1:0] minus_prev_n;
	logic halt_n;
	logic any_flt_en;
	esh_axis_req_t req [`ESH_NUM_AXES];
	esh_axis_req_t next_req [`ESH_NUM_AXES];

	// Per-axis configuration and pin mapping.
	assign cfg[0] = x_axis_mode_cfg_three;
	assign cfg[1] = y_axis_mode_cfg_three;
	assign plus_pin_n = {y_ext_plus_start, x_ext_plus_start};
	assign minus_pin_n = {y_ext_minus_start, x_ext_minus_start};
	assign any_flt_en = cfg[0].flt_en | cfg[1].flt_en;

	// The halt filter follows the filter enable of either axis, because the
	// single halt pin serves both axes and must not be filtered for one axis
	// and raw for the other.
	// Halt input: fixed active-low polarity, no inversion option exists.
	// fixed polarity
	esh_in_filter u_halt_flt (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin_n(global_halt_n),
		.flt_en(any_flt_en),
		.level_n(halt_n)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Per-axis start logic.
	// Each axis holds a small state machine.
	// IDLE waits for a start according to the configured external mode.
	// FIXED covers a fixed-length drive and ignores further start edges until
	// the pulse generator reports drive_done for this axis.
	// CONT keeps a run request up while the filtered start input stays low.
	// HALT is entered from any state while the filtered halt input is low and
	// is left only once that input has returned high.
	generate
		for (genvar a = 0; a < `ESH_NUM_AXES; a++) begin : g_axis
			// Local state of one axis; the generate loop repeats it per axis.
			esh_axis_state_t st;
			esh_axis_state_t next_st;
			logic err;
			logic next_err;
			logic plus_fall;
			logic minus_fall;

			esh_in_filter u_plus_flt (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.pin_n(plus_pin_n[a]),
				.flt_en(cfg[a].flt_en),
				.level_n(plus_n[a])
			);
			esh_in_filter u_minus_flt (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.pin_n(minus_pin_n[a]),
				.flt_en(cfg[a].flt_en),
				.level_n(minus_n[a])
			);

			// The edge detectors look at the filtered level, so a bouncing contact
			// yields one start and not a burst of them.
			// Their history flops reset high, the idle level of the pins, so that the
			// release of reset never looks like a falling edge.
			// edges on filtered
			assign plus_fall = plus_prev_n[a] & ~plus_n[a];
			assign minus_fall = minus_prev_n[a] & ~minus_n[a];

			// Next state, requests and error flag for this axis.
			always_comb begin
				next_st = st;
				next_err = err;
				next_req[a] = '0;
				// A clear in the same cycle as a halt loses: the halt branch
				// below sets the flag again after the clear has been applied.
				if (halt_error_clear[a]) begin
					next_err = 1'b0;
				end
				case (st)
					ESH_ST_IDLE: begin
						// Plus has priority when both start inputs fall together.
						// mode select
						if (cfg[a].ext_mode == ESH_EXT_FIXED) begin
							if (plus_fall) begin
								next_req[a].start_plus = 1'b1;
								next_st = ESH_ST_FIXED;
							end else if (minus_fall) begin
								next_req[a].start_minus = 1'b1;
								next_st = ESH_ST_FIXED;
							end
						end else if (cfg[a].ext_mode == ESH_EXT_CONT) begin
							if (!plus_n[a] || !minus_n[a]) begin
								next_st = ESH_ST_CONT;
							end
						end
					end
					ESH_ST_FIXED: begin
						// The drive length is counted by the pulse generator, not here.
						if (drive_done[a]) begin
							next_st = ESH_ST_IDLE;
						end
					end
					ESH_ST_CONT: begin
						// Leaving continuous mode or releasing both inputs ends the run at once.
						// plus level run
						if (cfg[a].ext_mode == ESH_EXT_CONT && !plus_n[a]) begin
							next_req[a].run_plus = 1'b1;
						end else if (cfg[a].ext_mode == ESH_EXT_CONT && !minus_n[a]) begin
							next_req[a].run_minus = 1'b1;
						end else begin
							next_st = ESH_ST_IDLE;
						end
					end
					ESH_ST_HALT: begin
						// Starts seen during the halt are dropped; in fixed mode a new edge is needed afterwards, in continuous mode a held level is enough.
						if (halt_n) begin
							next_st = ESH_ST_IDLE;
						end
					end
					default: begin
						// An unused encoding falls back to IDLE.
						next_st = ESH_ST_IDLE;
					end
				endcase
				// The halt overrides every other decision of this cycle, including a
				// start that would otherwise be issued.
				// immediate halt
				if (!halt_n) begin
					next_req[a] = '0;
					next_req[a].halt = 1'b1;
					next_st = ESH_ST_HALT;
					next_err = 1'b1;
				end
			end

			// Registering the requests here keeps every output flop-driven and
			// costs one cycle of latency against the pin.
			// Axis state registers.
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					st <= ESH_ST_IDLE;
					err <= 1'b0;
					plus_prev_n[a] <= 1'b1;
					minus_prev_n[a] <= 1'b1;
					req[a] <= '0;
				end else begin
					st <= next_st;
					err <= next_err;
					plus_prev_n[a] <= plus_n[a];
					minus_prev_n[a] <= minus_n[a];
					req[a] <= next_req[a];
				end
			end

			assign halt_error_flag[a] = err;
			assign axis_state[a] = st;
		end
	endgenerate

	// The per-axis requests leave as two separate structs so that each axis
	// can be wired to its own pulse generator.
	// Request outputs come straight from the per-axis request registers.
	assign x_req = req[0];
	assign y_req = req[1];
endmodule // esh_ext_start_halt

/* esh_ext_start_halt_monitor.sv */
// Checker for the external start and halt logic.
`timescale 1ns/10ps
`include "esh_defs.svh"
module esh_ext_start_halt_monitor
	import esh_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic x_ext_plus_start,
	input wire logic global_halt_n,
	input wire esh_axis_cfg_t x_axis_mode_cfg_three,
	input wire logic [`ESH_NUM_AXES-1:0] halt_error_clear,
	input wire esh_axis_req_t x_req,
	input wire logic [`ESH_NUM_AXES-1:0] halt_error_flag,
	input wire esh_axis_state_t [`ESH_NUM_AXES-1:0] axis_state
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	property p_halt; !global_halt_n [*8] |-> ##[1:5] x_req.halt; endproperty
	a_halt: assert property (p_halt) else $error("halt not raised");
	property p_flag; $rose(x_req.halt) |-> ##[0:1] halt_error_flag == 2'b11; endproperty
	a_flag: assert property (p_flag) else $error("error flags not set");
	property p_quiet; x_req.halt |-> !x_req.run_plus && !x_req.run_minus && !x_req.start_plus; endproperty
	a_quiet: assert property (p_quiet) else $error("drive during halt");
	property p_pulse; x_req.start_plus |=> !x_req.start_plus; endproperty
	a_pulse: assert property (p_pulse) else $error("start pulse too long");
	property p_fixst; $rose(x_req.start_plus) |-> axis_state[0] == ESH_ST_FIXED; endproperty
	a_fixst: assert property (p_fixst) else $error("state not fixed");
	property p_cont; x_req.run_plus |-> $past(x_axis_mode_cfg_three.ext_mode) == ESH_EXT_CONT; endproperty
	a_cont: assert property (p_cont) else $error("run outside continuous mode");
	property p_edge; $fell(x_ext_plus_start) && x_axis_mode_cfg_three == 3'h1 && global_halt_n
		&& axis_state[0] == ESH_ST_IDLE |-> ##4 x_req.start_plus; endproperty
	a_edge: assert property (p_edge) else $error("start latency wrong");
	property p_stick; halt_error_flag[0] && !halt_error_clear[0] |=> halt_error_flag[0]; endproperty
	a_stick: assert property (p_stick) else $error("error flag lost");
	property p_mpulse; x_req.start_minus |=> !x_req.start_minus; endproperty
	a_mpulse: assert property (p_mpulse) else $error("minus start pulse too long");
	property p_fixmin; $rose(x_req.start_minus) |-> axis_state[0] == ESH_ST_FIXED; endproperty
	a_fixmin: assert property (p_fixmin) else $error("state not fixed after minus start");
	property p_onedir; x_req.run_plus |-> !x_req.run_minus; endproperty
	a_onedir: assert property (p_onedir) else $error("both run directions raised");
endmodule // esh_ext_start_halt_monitor
bind esh_ext_start_halt esh_ext_start_halt_monitor u_mon (.ref_clk(ref_clk), .rst_n(rst_n),
	.x_ext_plus_start(x_ext_plus_start), .global_halt_n(global_halt_n),
	.x_axis_mode_cfg_three(x_axis_mode_cfg_three), .halt_error_clear(halt_error_clear),
	.x_req(x_req), .halt_error_flag(halt_error_flag), .axis_state(axis_state));

/* esh_sw_model.sv */
// Model of the external switches on the start and halt pins.
`timescale 1ns/10ps
module esh_sw_model (
	input wire logic ref_clk,
	input wire logic [4:0] press,
	output logic [4:0] pin_n
);
	logic [1:0] hold = 2'h0;
	// Released pins go high through the pull-up; halt is held low three cycles past the press.
	// minimum halt width
	always @(posedge ref_clk) hold <= press[4] ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
	assign pin_n = ~{press[4] | (hold != 2'h0), press[3:0]};
endmodule // esh_sw_model

/* esh_ext_start_halt_tb.sv */
// Testbench of the external start and halt logic.
`timescale 1ns/10ps
module esh_ext_start_halt_tb;
	import esh_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] press = 5'h0;
	logic [4:0] pin_n;
	esh_axis_cfg_t xc = 3'h0;
	esh_axis_cfg_t yc = 3'h0;
	logic [1:0] done = 2'h0;
	logic [1:0] clr = 2'h0;
	esh_axis_req_t x_req;
	esh_axis_req_t y_req;
	logic [1:0] flag;
	esh_axis_state_t [1:0] st;
	int n_fail = 0;
	int checked = 0;
	int i;
	logic [7:0] acc;
	always #2.5 ref_clk = ~ref_clk;
	esh_sw_model u_esh_sw_model (.ref_clk(ref_clk), .press(press), .pin_n(pin_n));
	esh_ext_start_halt u_esh_ext_start_halt (.ref_clk(ref_clk), .rst_n(rst_n), .x_ext_plus_start(pin_n[0]),
		.x_ext_minus_start(pin_n[1]), .y_ext_plus_start(pin_n[2]), .y_ext_minus_start(pin_n[3]),
		.global_halt_n(pin_n[4]), .x_axis_mode_cfg_three(xc), .y_axis_mode_cfg_three(yc), .drive_done(done),
		.halt_error_clear(clr), .x_req(x_req), .y_req(y_req), .halt_error_flag(flag), .axis_state(st));
	////////////////////////////////////////////////////////////////////////////////
	// Compares one value and counts it.
	task chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task close_out;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Collects every start and run request seen over n cycles.
	task watch(input int n);
		acc = 8'h00;
		repeat (n) begin
			cyc(1);
			acc = acc | {x_req[4:1], y_req[4:1]};
		end
	endtask
	// Fixed plus on X, then fixed minus on Y.
	task fixed_run;
		xc = 3'h1;
		yc = 3'h1;
		press = 5'h1;
		for (i = 0; i < 20 && x_req.start_plus !== 1'b1; i++) cyc(1);
		chk(x_req.start_plus, 1'b1, "x start_plus");
		chk(st[0], ESH_ST_FIXED, "x state");
		press = 5'h8;
		for (i = 0; i < 20 && y_req.start_minus !== 1'b1; i++) cyc(1);
		chk(y_req.start_minus, 1'b1, "y start_minus");
		press = 5'h0;
		done = 2'h3;
		cyc(1);
		done = 2'h0;
		cyc(2);
		chk(st, 4'h0, "states idle");
	endtask
	// Minus on X and plus on Y; new edges are refused while the drives run.
	task fixed_swap;
		press = 5'h6;
		for (i = 0; i < 20 && x_req.start_minus !== 1'b1; i++) cyc(1);
		chk({x_req.start_minus, y_req.start_plus, st}, 6'h35, "swapped starts");
		press = 5'h0;
		cyc(6);
		press = 5'h6;
		watch(10);
		chk(acc, 8'h00, "starts while fixed");
		chk(st, 4'h5, "states still fixed");
		press = 5'h0;
		done = 2'h3;
		cyc(1);
		done = 2'h0;
		cyc(2);
		chk(st, 4'h0, "states idle after swap");
	endtask
	// Mode off ignores every start pin.
	task off_run;
		xc = 3'h0;
		yc = 3'h0;
		press = 5'hf;
		watch(12);
		chk(acc, 8'h00, "requests in off mode");
		chk(st, 4'h0, "states in off mode");
		press = 5'h0;
		cyc(4);
	endtask
	// Filtered continuous drives on both axes.
	task cont_run;
		xc = 3'h6;
		yc = 3'h6;
		press = 5'h9;
		cyc(20);
		chk({x_req.run_plus, y_req.run_minus, st[0]}, 4'hf, "run levels");
		press = 5'h0;
		cyc(20);
		chk({x_req.run_plus, y_req.run_minus}, 2'h0, "run released");
		press = 5'h6;
		cyc(20);
		chk({x_req.run_minus, y_req.run_plus, st}, 6'h3f, "swapped run levels");
		press = 5'h3;
		cyc(20);
		chk({x_req.run_plus, x_req.run_minus, y_req.run_plus}, 3'h4, "plus wins");
		press = 5'h0;
		cyc(20);
		chk({x_req[4:1], y_req[4:1]}, 8'h00, "all runs released");
	endtask
	// Pulses shorter than the filter time are swallowed.
	task glitch_run;
		press = 5'h1;
		cyc(5);
		press = 5'h0;
		watch(20);
		chk(acc, 8'h00, "short start filtered");
		press = 5'h10;
		cyc(1);
		press = 5'h0;
		cyc(20);
		chk({x_req.halt, y_req.halt, flag}, 4'h0, "short halt filtered");
	endtask
	// Halt stops both axes and leaves sticky flags.
	task halt_run;
		press = 5'h1;
		cyc(20);
		press = 5'h10;
		cyc(16);
		chk({x_req.halt, y_req.halt, x_req.run_plus, st[0]}, 5'h1a, "halt");
		chk(flag, 2'h3, "flags set");
		clr = 2'h3;
		cyc(1);
		clr = 2'h0;
		cyc(1);
		chk(flag, 2'h3, "set beats clear");
		press = 5'h0;
		cyc(20);
		chk(flag, 2'h3, "flags held");
		clr = 2'h3;
		cyc(1);
		clr = 2'h0;
		cyc(2);
		chk(flag, 2'h0, "flags cleared");
	endtask
	// A reset during a halt clears requests, flags and states.
	task reset_run;
		press = 5'h10;
		cyc(16);
		chk(flag, 2'h3, "flags before reset");
		press = 5'h0;
		rst_n = 1'b0;
		cyc(2);
		chk({x_req, flag}, 7'h00, "x outputs in reset");
		chk(y_req, 5'h00, "y outputs in reset");
		chk(st, 4'h0, "states in reset");
		cyc(2);
		rst_n = 1'b1;
		cyc(2);
		chk({x_req.halt, y_req.halt, flag, st}, 8'h00, "after reset release");
	endtask
	initial begin
		cyc(12);
		rst_n = 1'b1;
		cyc(2);
		fixed_run();
		fixed_swap();
		off_run();
		cont_run();
		glitch_run();
		halt_run();
		reset_run();
		close_out();
	end
	// Watchdog against a hang.
	initial begin
		#5000;
		n_fail++;
		close_out();
	end
endmodule // esh_ext_start_halt_tb
